//--- include/i2c_engine_pkg.sv
// Package with register map, field positions, reset values and timing of the byte engine.
package i2c_engine_pkg;

  // Register offsets on the special-function register port.
  localparam logic [15:0] TARGET_ADDR_OFS = 16'hFF80;
  localparam logic [15:0] FIRST_TX_OFS = 16'hFF81;
  localparam logic [15:0] SECOND_TX_OFS = 16'hFF82;
  localparam logic [15:0] FIRST_RX_OFS = 16'hFF83;
  localparam logic [15:0] SECOND_RX_OFS = 16'hFF84;
  localparam logic [15:0] XFER_CTL_STAT_OFS = 16'hFF85;
  localparam logic [15:0] EXT_IRQ_SIX_CTL_OFS = 16'hFF95;

  // Field positions.
  localparam int DIR_BIT_POS = 0;
  localparam int TWO_BYTE_SEL_POS = 0;
  localparam int XFER_GO_BUSY_POS = 1;
  localparam int NACK_ERROR_POS = 2;
  localparam int XFER_DONE_FLAG_POS = 2;
  localparam int XFER_DONE_IRQ_EN_POS = 3;

  // Reset value of every register of the block.
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Bus timing: serial clock rate and link clock rate, each in kHz.
  localparam int SCL_FREQ_KHZ = 400;
  localparam int LINK_CLK_KHZ = 15625;
  localparam int PHASES_PER_BIT = 4;
  // Link cycles per quarter bit, rounded up so the bus never runs above its rate.
  localparam int QUARTER_CYCLES_RAW = (LINK_CLK_KHZ + PHASES_PER_BIT * SCL_FREQ_KHZ - 1) / (PHASES_PER_BIT * SCL_FREQ_KHZ);
  localparam int QUARTER_CYCLES = (QUARTER_CYCLES_RAW < 1) ? 1 : QUARTER_CYCLES_RAW;

  // Result buffer shape: one word is nack flag, first and second received byte.
  localparam int RESULT_WIDTH = 17;
  localparam int RESULT_DEPTH = 8;

  // Link sequencer states.
  typedef enum logic [2:0] {
    L_IDLE,
    L_START,
    L_BIT,
    L_ACK,
    L_STOP
  } link_state_t;

endpackage

//--- rtl/i2c_master_byte_engine.sv
// Byte-oriented two-wire master engine with its register file, link sequencer and result buffer.
//
// Behaviour
// - two-byte write sends the second transmit byte after the first.
// - a read stores the first received byte in the first receive register.
// - two-byte read stores a second received byte in the second receive register.
// - nack error bit sets when the acknowledge sampled after the address or a written byte is high.
// - nack error bit clears when a new transaction starts.
// - writing one to the go bit while not busy starts a transaction with current settings.
// - the go bit clears itself when the transaction ends.
// - the go bit reads high while the transfer is in progress.
// - control bit zero selects two-byte (1) or one-byte (0) transfers.
// - the control register reads zero after reset.
// - address register holds seven-bit target address above a direction bit.
// - the first written data byte comes from the first transmit register.
// - completion raises a done flag that drops when the next transaction starts.
// - the serial clock runs at 390.625 kHz (40 link cycles per bit), the 400 kHz target rounded down, from the link time base.

// Synchronous FIFO with valid and ready on both sides.
module result_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } fifo_t;

  fifo_t state_reg;
  fifo_t state_next;
  logic full;
  logic empty;

  // Full when the pointers differ only in the wrap bit.
  assign full = (state_reg.wptr[AW] != state_reg.rptr[AW]) && (state_reg.wptr[AW-1:0] == state_reg.rptr[AW-1:0]);
  assign empty = (state_reg.wptr == state_reg.rptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = state_reg.mem[state_reg.rptr[AW-1:0]];

  // Pointer and storage update.
  always_comb begin
    state_next = state_reg;
    if (in_valid && !full) begin
      state_next.mem[state_reg.wptr[AW-1:0]] = in_data;
      state_next.wptr = state_reg.wptr + 1'b1;
    end
    if (out_ready && !empty) begin
      state_next.rptr = state_reg.rptr + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// Link sequencer on the link clock; drives the open-drain serial pins.
module i2c_link_seq (
  // Clock and reset.
  input wire logic clk_link,
  input wire logic rst,
  // Request from the register side; only two_byte is held stable while busy, all settings are captured at the start.
  input wire logic go_tgl,
  input wire logic [7:0] addr_byte,
  input wire logic [7:0] tx1,
  input wire logic [7:0] tx2,
  input wire logic two_byte,
  // Results to the register side.
  output logic done_tgl,
  output logic [7:0] rx1,
  output logic [7:0] rx2,
  output logic nack,
  // Serial pins.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  typedef struct packed {
    i2c_engine_pkg::link_state_t state;
    logic [7:0] qcnt;
    logic [1:0] q;
    logic [2:0] bitn;
    logic [1:0] byten;
    logic rd;
    logic len;
    logic [7:0] shreg;
    logic [7:0] tx1;
    logic [7:0] tx2;
    logic [7:0] rx1;
    logic [7:0] rx2;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic scl_out;
    logic sda_out;
    logic go_meta;
    logic go_sync;
    logic go_seen;
    logic scl_meta;
    logic scl_sync;
    logic sda_meta;
    logic sda_sync;
    logic done_tgl;
  } link_t;

  link_t state_reg;
  link_t state_next;
  logic tick;
  logic is_tx;
  logic [1:0] last_byte;

  assign tick = (state_reg.qcnt == 8'(i2c_engine_pkg::QUARTER_CYCLES - 1));
  assign is_tx = (state_reg.byten == 2'd0) || !state_reg.rd;
  assign last_byte = state_reg.len ? 2'd2 : 2'd1;

  // Sequencer: four quarter phases per bit, serial clock released in phases one and two.
  always_comb begin
    state_next = state_reg;
    state_next.go_meta = go_tgl;
    state_next.go_sync = state_reg.go_meta;
    state_next.scl_meta = scl_in;
    state_next.scl_sync = state_reg.scl_meta;
    state_next.sda_meta = sda_in;
    state_next.sda_sync = state_reg.sda_meta;
    state_next.qcnt = tick ? 8'h00 : state_reg.qcnt + 8'h01;
    unique case (state_reg.state)
      i2c_engine_pkg::L_IDLE: begin
        state_next.qcnt = 8'h00;
        state_next.q = 2'd0;
        state_next.scl_oe = 1'b0;
        state_next.sda_oe = 1'b0;
        if (state_reg.go_sync != state_reg.go_seen) begin
          state_next.go_seen = state_reg.go_sync;
          state_next.shreg = addr_byte;
          state_next.rd = addr_byte[i2c_engine_pkg::DIR_BIT_POS];
          state_next.tx1 = tx1;
          state_next.tx2 = tx2;
          state_next.len = two_byte;
          state_next.nack = 1'b0;
          state_next.byten = 2'd0;
          state_next.bitn = 3'd7;
          state_next.state = i2c_engine_pkg::L_START;
        end
      end
      i2c_engine_pkg::L_START: begin
        if (tick) begin
          state_next.q = state_reg.q + 2'd1;
          if (state_reg.q == 2'd0) begin
            state_next.sda_oe = 1'b1;
          end else begin
            state_next.scl_oe = 1'b1;
            state_next.sda_oe = !state_reg.shreg[7];
            state_next.q = 2'd0;
            state_next.state = i2c_engine_pkg::L_BIT;
          end
        end
      end
      default: begin
        if (tick && !(state_reg.q == 2'd1 && !state_reg.scl_sync)) begin
          state_next.q = state_reg.q + 2'd1;
          unique case (state_reg.q)
            2'd0: begin
              state_next.scl_oe = 1'b0;
            end
            2'd1: begin
              if (state_reg.state == i2c_engine_pkg::L_BIT) begin
                state_next.shreg = {state_reg.shreg[6:0], state_reg.sda_sync};
              end else if (state_reg.state == i2c_engine_pkg::L_ACK) begin
                if (is_tx && state_reg.sda_sync) begin
                  state_next.nack = 1'b1;
                end
                if (!is_tx && state_reg.byten == 2'd1) begin
                  state_next.rx1 = state_reg.shreg;
                end
                if (!is_tx && state_reg.byten == 2'd2) begin
                  state_next.rx2 = state_reg.shreg;
                end
              end else begin
                state_next.sda_oe = 1'b0;
              end
            end
            2'd2: begin
              if (state_reg.state != i2c_engine_pkg::L_STOP) begin
                state_next.scl_oe = 1'b1;
              end
            end
            default: begin
              if (state_reg.state == i2c_engine_pkg::L_BIT) begin
                if (state_reg.bitn == 3'd0) begin
                  state_next.state = i2c_engine_pkg::L_ACK;
                  state_next.sda_oe = is_tx ? 1'b0 : (state_reg.byten != last_byte);
                end else begin
                  state_next.bitn = state_reg.bitn - 3'd1;
                  state_next.sda_oe = is_tx ? !state_reg.shreg[7] : 1'b0;
                end
              end else if (state_reg.state == i2c_engine_pkg::L_ACK) begin
                if (state_reg.nack || state_reg.byten == last_byte) begin
                  state_next.state = i2c_engine_pkg::L_STOP;
                  state_next.sda_oe = 1'b1;
                end else begin
                  state_next.byten = state_reg.byten + 2'd1;
                  state_next.bitn = 3'd7;
                  state_next.shreg = (state_reg.byten == 2'd0) ? state_reg.tx1 : state_reg.tx2;
                  state_next.sda_oe = !state_reg.rd && !((state_reg.byten == 2'd0) ? state_reg.tx1[7] : state_reg.tx2[7]);
                  state_next.state = i2c_engine_pkg::L_BIT;
                end
              end else begin
                state_next.done_tgl = !state_reg.done_tgl;
                state_next.state = i2c_engine_pkg::L_IDLE;
              end
            end
          endcase
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign done_tgl = state_reg.done_tgl;
  assign rx1 = state_reg.rx1;
  assign rx2 = state_reg.rx2;
  assign nack = state_reg.nack;
  assign scl_out = state_reg.scl_out;
  assign scl_oe = state_reg.scl_oe;
  assign sda_out = state_reg.sda_out;
  assign sda_oe = state_reg.sda_oe;

  // Idle bus is fully released.
  property p_idle_released;
    @(posedge clk_link) disable iff (rst)
    (state_reg.state == i2c_engine_pkg::L_IDLE && $past(state_reg.state) == i2c_engine_pkg::L_IDLE) |-> !scl_oe && !sda_oe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("Bus not released while idle.");

  // The final read byte is never acknowledged.
  property p_last_read_nack;
    @(posedge clk_link) disable iff (rst)
    (state_reg.state == i2c_engine_pkg::L_ACK && state_reg.rd && state_reg.byten == last_byte) |-> !sda_oe;
  endproperty
  a_last_read_nack: assert property (p_last_read_nack) else $error("Final read byte was acknowledged.");
endmodule

// Top: register file on the clk_sys side and the link sequencer on clk_link.
module i2c_master_byte_engine (
  // Clocks and reset.
  input wire logic clk_sys,
  input wire logic clk_link,
  input wire logic rst,
  // Special-function register port.
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Completion interrupt.
  output logic ext_irq6,
  // Serial pins.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  typedef struct packed {
    logic [7:0] target_addr_reg;
    logic [7:0] first_tx;
    logic [7:0] second_tx;
    logic [7:0] first_rx;
    logic [7:0] second_rx;
    logic two_byte_sel;
    logic busy;
    logic nack;
    logic done_flag;
    logic irq_en;
    logic irq_out;
    logic [7:0] rdata;
    logic go_tgl;
    logic done_meta;
    logic done_sync;
    logic done_seen;
    logic pend;
  } sys_t;

  sys_t state_reg;
  sys_t state_next;
  logic link_done_tgl;
  logic [7:0] link_rx1;
  logic [7:0] link_rx2;
  logic link_nack;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [i2c_engine_pkg::RESULT_WIDTH-1:0] fifo_out_data;
  logic pop;
  logic start_req;

  // Results drain while no register read is under way, so a read never sees a half update.
  assign pop = fifo_out_valid && !sfr_rd;
  assign start_req = sfr_wr && sfr_addr == i2c_engine_pkg::XFER_CTL_STAT_OFS && sfr_wdata[i2c_engine_pkg::XFER_GO_BUSY_POS]
    && !state_reg.busy;

  // Register file, start handling and completion bookkeeping.
  always_comb begin
    state_next = state_reg;
    state_next.done_meta = link_done_tgl;
    state_next.done_sync = state_reg.done_meta;
    if (state_reg.pend && fifo_in_ready) begin
      state_next.pend = 1'b0;
    end
    if (state_reg.done_sync != state_reg.done_seen) begin
      state_next.done_seen = state_reg.done_sync;
      state_next.pend = 1'b1;
    end
    if (pop) begin
      state_next.nack = fifo_out_data[16];
      state_next.first_rx = fifo_out_data[15:8];
      state_next.second_rx = fifo_out_data[7:0];
      state_next.busy = 1'b0;
      state_next.done_flag = 1'b1;
    end
    if (sfr_wr) begin
      unique case (sfr_addr)
        i2c_engine_pkg::TARGET_ADDR_OFS: state_next.target_addr_reg = sfr_wdata;
        i2c_engine_pkg::FIRST_TX_OFS: state_next.first_tx = sfr_wdata;
        i2c_engine_pkg::SECOND_TX_OFS: state_next.second_tx = sfr_wdata;
        i2c_engine_pkg::XFER_CTL_STAT_OFS: begin
          if (!state_reg.busy) begin
            state_next.two_byte_sel = sfr_wdata[i2c_engine_pkg::TWO_BYTE_SEL_POS];
          end
        end
        i2c_engine_pkg::EXT_IRQ_SIX_CTL_OFS: begin
          state_next.irq_en = sfr_wdata[i2c_engine_pkg::XFER_DONE_IRQ_EN_POS];
        end
        default: begin
        end
      endcase
    end
    if (start_req) begin
      state_next.busy = 1'b1;
      state_next.nack = 1'b0;
      state_next.done_flag = 1'b0;
      state_next.go_tgl = !state_reg.go_tgl;
    end
    state_next.irq_out = state_next.done_flag && state_next.irq_en;
    if (sfr_rd) begin
      unique case (sfr_addr)
        i2c_engine_pkg::TARGET_ADDR_OFS: state_next.rdata = state_reg.target_addr_reg;
        i2c_engine_pkg::FIRST_TX_OFS: state_next.rdata = state_reg.first_tx;
        i2c_engine_pkg::SECOND_TX_OFS: state_next.rdata = state_reg.second_tx;
        i2c_engine_pkg::FIRST_RX_OFS: state_next.rdata = state_reg.first_rx;
        i2c_engine_pkg::SECOND_RX_OFS: state_next.rdata = state_reg.second_rx;
        i2c_engine_pkg::XFER_CTL_STAT_OFS: state_next.rdata = {5'h00, state_reg.nack, state_reg.busy,
          state_reg.two_byte_sel};
        i2c_engine_pkg::EXT_IRQ_SIX_CTL_OFS: state_next.rdata = {4'h0, state_reg.irq_en, state_reg.done_flag, 2'h0};
        default: state_next.rdata = i2c_engine_pkg::BYTE_RESET;
      endcase
    end
  end

  // State register; every field resets to zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Result buffer between the completion event and the receive registers.
  result_fifo #(
    .WIDTH(i2c_engine_pkg::RESULT_WIDTH),
    .DEPTH(i2c_engine_pkg::RESULT_DEPTH)
  ) u_fifo (
    .clk(clk_sys),
    .rst(rst),
    .in_valid(state_reg.pend),
    .in_data({link_nack, link_rx1, link_rx2}),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(!sfr_rd)
  );

  // Link sequencer; settings cross without synchronisers and are captured once at the start; only the two-byte select is locked while busy.
  i2c_link_seq u_link (
    .clk_link(clk_link),
    .rst(rst),
    .go_tgl(state_reg.go_tgl),
    .addr_byte(state_reg.target_addr_reg),
    .tx1(state_reg.first_tx),
    .tx2(state_reg.second_tx),
    .two_byte(state_reg.two_byte_sel),
    .done_tgl(link_done_tgl),
    .rx1(link_rx1),
    .rx2(link_rx2),
    .nack(link_nack),
    .scl_in(scl_in),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe)
  );

  assign sfr_rdata = state_reg.rdata;
  assign ext_irq6 = state_reg.irq_out;

  // A start sets busy and clears the error and done flag.
  property p_start_effects;
    @(posedge clk_sys) disable iff (rst)
    start_req |=> state_reg.busy && !state_reg.nack && !state_reg.done_flag;
  endproperty
  a_start_effects: assert property (p_start_effects) else $error("Start did not set busy and clear flags.");

  // Nack error clears on start.
  property p_start_clears_nack;
    @(posedge clk_sys) disable iff (rst)
    start_req |=> !state_reg.nack;
  endproperty
  a_start_clears_nack: assert property (p_start_clears_nack) else $error("Nack error survived a start.");

  // Completion ends busy and raises the done flag.
  property p_done_effects;
    @(posedge clk_sys) disable iff (rst)
    pop |=> !state_reg.busy && state_reg.done_flag;
  endproperty
  a_done_effects: assert property (p_done_effects) else $error("Completion did not end busy.");

  // The nack error follows the result of the transaction.
  property p_nack_result;
    @(posedge clk_sys) disable iff (rst)
    pop |=> state_reg.nack == $past(fifo_out_data[16]);
  endproperty
  a_nack_result: assert property (p_nack_result) else $error("Nack error does not match result.");

  // Received bytes land in the receive registers.
  property p_rx_bytes;
    @(posedge clk_sys) disable iff (rst)
    pop |=> state_reg.first_rx == $past(fifo_out_data[15:8]) && state_reg.second_rx == $past(fifo_out_data[7:0]);
  endproperty
  a_rx_bytes: assert property (p_rx_bytes) else $error("Receive registers not loaded.");

  // Status read reports busy as it was at the read.
  property p_busy_read;
    @(posedge clk_sys) disable iff (rst)
    (sfr_rd && sfr_addr == i2c_engine_pkg::XFER_CTL_STAT_OFS) |=> sfr_rdata[1] == $past(state_reg.busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("Busy bit misreported.");

  // Interrupt output is high with flag and enable, at the latest one cycle after they rise.
  property p_irq_follows;
    @(posedge clk_sys) disable iff (rst)
    (state_reg.done_flag && state_reg.irq_en) |-> ext_irq6 || $past(!state_reg.done_flag || !state_reg.irq_en);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("Interrupt output not raised.");
endmodule

//--- verification/i2c_target_model.sv
// Behavioural two-wire target that answers the byte engine on an open-drain bus.
module i2c_target_model (
  // Bus levels as seen on the wires.
  input wire logic scl,
  input wire logic sda,
  // High while the target pulls the data line low.
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rd_bytes [2];
  logic nack_addr;
  logic [7:0] seen [$];
  logic [7:0] ack_log;
  logic [7:0] b;
  logic stop;

  // Shifts in one byte, most significant bit first; a rising data line with the clock high ends the frame.
  task automatic get_byte();
    stop = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl);
      b[i] = sda;
      @(negedge scl or posedge sda);
      if (scl) begin
        stop = 1'b1;
        return;
      end
    end
  endtask

  // Frame handler: waits for a start, takes the address and then serves a write or a read.
  initial begin
    sda_pull = 1'b0;
    nack_addr = 1'b0;
    ack_log = 8'h00;
    rd_bytes[0] = 8'hA5;
    rd_bytes[1] = 8'h3C;
    forever begin
      @(negedge sda iff scl === 1'b1);
      get_byte();
      if (stop) continue;
      seen.push_back(b);
      sda_pull = !nack_addr;
      @(negedge scl);
      sda_pull = 1'b0;
      if (nack_addr) continue;
      if (b[0]) begin
        for (int k = 0; k < 2; k++) begin
          for (int i = 7; i >= 0; i--) begin
            sda_pull = !rd_bytes[k][i];
            @(negedge scl);
          end
          sda_pull = 1'b0;
          @(posedge scl);
          ack_log = {ack_log[5:0], 1'b1, sda};
          if (sda) break;
          @(negedge scl);
        end
      end else begin
        forever begin
          get_byte();
          if (stop) break;
          seen.push_back(b);
          sda_pull = 1'b1;
          @(negedge scl);
          sda_pull = 1'b0;
        end
      end
    end
  end
endmodule

//--- verification/i2c_master_byte_engine_tb_top.sv
// Register-level testbench of the byte engine with a target model on the bus.
`define CHK(w, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", w, e, g); end end
module i2c_master_byte_engine_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] ADR = i2c_engine_pkg::TARGET_ADDR_OFS;
  localparam logic [15:0] CTL = i2c_engine_pkg::XFER_CTL_STAT_OFS;
  localparam logic [15:0] IRQ = i2c_engine_pkg::EXT_IRQ_SIX_CTL_OFS;
  localparam logic [15:0] RX1 = i2c_engine_pkg::FIRST_RX_OFS;
  localparam logic [15:0] RX2 = i2c_engine_pkg::SECOND_RX_OFS;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b0;
  logic [15:0] sfr_addr = 16'h0000;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic ext_irq6, scl_out, scl_oe, sda_out, sda_oe, pull;
  wire logic scl;
  wire logic sda;
  int n_mismatch = 0;
  int total_checks = 0;

  // Open-drain wires with pull-ups.
  assign scl = scl_oe ? scl_out : 1'b1;
  assign sda = (sda_oe ? sda_out : 1'b1) & ~pull;

  // Register clock; the link clock starts with an unrelated phase offset.
  always #4 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #32 clk_link = ~clk_link;
  end

  i2c_master_byte_engine DUT (.clk_sys(clk_sys), .clk_link(clk_link), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_irq6(ext_irq6),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  i2c_target_model tgt (.scl(scl), .sda(sda), .sda_pull(pull));

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask

  // One-cycle register read; data is taken just after the read edge.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string w);
    logic [7:0] d;
    rd(a, d);
    `CHK(w, e, d)
  endtask

  // Loads address and data, then starts the transfer.
  task automatic go(input logic [7:0] adr, input logic [7:0] t1, input logic [7:0] t2, input logic [7:0] c);
    wr(ADR, adr);
    wr(i2c_engine_pkg::FIRST_TX_OFS, t1);
    wr(i2c_engine_pkg::SECOND_TX_OFS, t2);
    wr(CTL, c);
  endtask

  // Polls the busy bit with a bounded count; address and data stay untouched meanwhile.
  task automatic wait_idle();
    logic [7:0] d;
    int n;
    n = 0;
    do begin
      rd(CTL, d);
      n++;
    end while (d[1] !== 1'b0 && n < 8000);
    if (d[1] !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic chk_seen(input logic [7:0] e [$]);
    `CHK("byte count", e.size(), tgt.seen.size())
    foreach (e[i]) if (i < tgt.seen.size()) `CHK("bus byte", e[i], tgt.seen[i])
    tgt.seen.delete();
  endtask

  // Main sequence.
  initial begin
    // Reset rises at time zero so the link domain sees its edge before its first clock.
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(CTL, 8'h00, "ctl reset");
    rdc(RX1, 8'h00, "rx1 reset");
    rdc(RX2, 8'h00, "rx2 reset");
    rdc(IRQ, 8'h00, "irq reg reset");
    rdc(16'hFF86, 8'h00, "unmapped");
    wr(IRQ, 8'h08);
    go(8'h54, 8'h11, 8'h22, 8'h03);
    rdc(CTL, 8'h03, "busy");
    wr(CTL, 8'h00);
    rdc(CTL, 8'h03, "busy held");
    wait_idle();
    rdc(CTL, 8'h01, "go cleared");
    rdc(IRQ, 8'h0C, "done flag");
    `CHK("irq line", 1'b1, ext_irq6)
    chk_seen('{8'h54, 8'h11, 8'h22});
    go(8'h54, 8'h11, 8'h99, 8'h02);
    rdc(IRQ, 8'h08, "flag dropped");
    `CHK("irq line low", 1'b0, ext_irq6)
    wait_idle();
    chk_seen('{8'h54, 8'h11});
    go(8'h55, 8'h00, 8'h00, 8'h03);
    wait_idle();
    rdc(RX1, 8'hA5, "rx1");
    rdc(RX2, 8'h3C, "rx2");
    `CHK("read acks", 8'h0B, tgt.ack_log)
    tgt.ack_log = 8'h00;
    tgt.rd_bytes[0] = 8'h5A;
    go(8'h55, 8'h00, 8'h00, 8'h02);
    wait_idle();
    rdc(RX1, 8'h5A, "rx1 single");
    `CHK("single ack", 8'h03, tgt.ack_log)
    tgt.nack_addr = 1'b1;
    tgt.seen.delete();
    go(8'h54, 8'h11, 8'h22, 8'h02);
    wait_idle();
    rdc(CTL, 8'h04, "nack error");
    chk_seen('{8'h54});
    tgt.nack_addr = 1'b0;
    wr(CTL, 8'h02);
    rdc(CTL, 8'h02, "nack cleared");
    wait_idle();
    chk_seen('{8'h54, 8'h11});
    end_sim();
  end
endmodule
